/* logic/aec_cfg.svh */
// register offsets, field positions and reset values of the adaptive equalizer control
`ifndef AEC_CFG_SVH
`define AEC_CFG_SVH

// ==========================================================================
// register offsets
`define AEC_ADDR_CTL 8'h42
`define AEC_ADDR_THOLD 8'h43
`define AEC_ADDR_RSVD_LO 8'h44
`define AEC_ADDR_RSVD_HI 8'h49
`define AEC_ADDR_CRC_CAP 8'h4a

// ==========================================================================
// control and crc capability register fields
`define AEC_ERRSEL_MSB 6
`define AEC_ERRSEL_LSB 4
`define AEC_ERRSEL_CLK 2
`define AEC_ERRSEL_ENC 1
`define AEC_ERRSEL_PAR 0
`define AEC_TWO_STEP_BIT 2
`define AEC_LOOP_ORDER_BIT 1
`define AEC_SF_EN_BIT 0
`define AEC_CTL_WMASK 8'h7f
`define AEC_CRC_FLAG_BIT 4

// ==========================================================================
// reset values
`define AEC_CTL_RESET 8'h71
`define AEC_THOLD_RESET 8'h01
`define AEC_CRC_CAP_RESET 8'h00
`define AEC_RDATA_RESET 8'h00

// ==========================================================================
// sweep constants
`define AEC_SF_CENTRE 4'h7
`define AEC_EQ_START 4'h0

`endif

/* logic/aec_pkg.sv */
// types shared by the adaptive equalizer control
`default_nettype none
package aec_pkg;

	// ==========================================================================
	// adaption state machine
	typedef enum logic [1:0] {
		AEC_SETTLE,
		AEC_VALIDATE,
		AEC_TRACK
	} aec_state_t;

endpackage
`default_nettype wire

/* logic/aec_err_accum.sv */
// selected link error gate and saturating error accumulator
`timescale 1ns/1ns
`default_nettype none
module aec_err_accum #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// control
	input wire logic i_clear,
	input wire logic [2:0] i_select,
	input wire logic [2:0] i_link_err,
	// results
	output logic o_err_any,
	output logic [CNT_W-1:0] o_err_count
);

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;

	// ==========================================================================
	// only enabled error kinds count
	assign o_err_any = |(i_select & i_link_err);
	assign o_err_count = count_reg;

	// next count: a new error wins over a clear
	always_comb begin
		count_next = count_reg;
		if (i_clear) begin
			count_next = o_err_any ? CNT_W'(1) : '0;
		end else if (o_err_any && (count_reg != {CNT_W{1'b1}})) begin
			count_next = count_reg + CNT_W'(1);
		end
	end

	// count register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

endmodule
`default_nettype wire

/* logic/aec_regs.sv */
// control, threshold and per-port crc capability registers with read port
`timescale 1ns/1ns
`default_nettype none
`include "aec_cfg.svh"
module aec_regs #(
	parameter int NUM_PORTS = 2,
	parameter int PSEL_W = 1
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// port select
	input wire logic [PSEL_W-1:0] i_rd_port_sel,
	input wire logic [NUM_PORTS-1:0] i_wr_port_en,
	// register contents
	output logic [7:0] o_ctl,
	output logic [7:0] o_thold,
	output logic [NUM_PORTS-1:0] o_crc_flag_en
);

	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic [7:0] thold_reg;
	logic [7:0] thold_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] cap_q [NUM_PORTS];

	assign o_ctl = ctl_reg;
	assign o_thold = thold_reg;
	assign o_reg_rdata = rdata_reg;

	// ==========================================================================
	// per-port crc capability copies, written through the port enables
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic [7:0] cap_reg;
		logic [7:0] cap_next;
		always_comb begin
			cap_next = cap_reg;
			if (i_reg_wr && (i_reg_addr == `AEC_ADDR_CRC_CAP) && i_wr_port_en[p]) begin
				cap_next = i_reg_wdata;
			end
		end
		always_ff @(posedge i_core_clk) begin
			if (i_rst) begin
				cap_reg <= `AEC_CRC_CAP_RESET;
			end else begin
				cap_reg <= cap_next;
			end
		end
		assign cap_q[p] = cap_reg;
		assign o_crc_flag_en[p] = cap_reg[`AEC_CRC_FLAG_BIT];
	end

	// ==========================================================================
	// shared registers and registered read data
	always_comb begin
		ctl_next = ctl_reg;
		thold_next = thold_reg;
		rdata_next = rdata_reg;
		if (i_reg_wr && (i_reg_addr == `AEC_ADDR_CTL)) begin
			ctl_next = i_reg_wdata & `AEC_CTL_WMASK; // top bit reads zero
		end
		if (i_reg_wr && (i_reg_addr == `AEC_ADDR_THOLD)) begin
			thold_next = i_reg_wdata;
		end
		if (i_reg_rd) begin
			rdata_next = 8'h00; // reserved and unmapped read as zero
			if (i_reg_addr == `AEC_ADDR_CTL) begin
				rdata_next = ctl_reg;
			end else if (i_reg_addr == `AEC_ADDR_THOLD) begin
				rdata_next = thold_reg;
			end else if ((i_reg_addr == `AEC_ADDR_CRC_CAP) && (int'(i_rd_port_sel) < NUM_PORTS)) begin
				rdata_next = cap_q[i_rd_port_sel];
			end
		end
	end

	// register update
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ctl_reg <= `AEC_CTL_RESET;
			thold_reg <= `AEC_THOLD_RESET;
			rdata_reg <= `AEC_RDATA_RESET;
		end else begin
			ctl_reg <= ctl_next;
			thold_reg <= thold_next;
			rdata_reg <= rdata_next;
		end
	end

endmodule
`default_nettype wire

/* logic/aec_ctrl.sv */
// adaptive equalizer control: error driven adaption, two-step validation, loop nesting, crc flag
`timescale 1ns/1ns
`default_nettype none
`include "aec_cfg.svh"
module aec_ctrl #(
	parameter int NUM_PORTS = 2,
	parameter int PSEL_W = 1,
	parameter int RELOCK_W = 16,
	parameter int EQ_W = 4,
	parameter logic [3:0] EQ_MAX = 4'hf
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// port select
	input wire logic [PSEL_W-1:0] i_rd_port_sel,
	input wire logic [NUM_PORTS-1:0] i_wr_port_en,
	// adaption inputs
	input wire logic [RELOCK_W-1:0] i_relock_period,
	input wire logic i_lock_async,
	input wire logic [2:0] i_link_err,
	input wire logic [3:0] i_sample_filter_lower_limit,
	input wire logic [3:0] i_sample_filter_upper_limit,
	// adaption outputs
	output logic [EQ_W-1:0] o_eq_setting,
	output logic [3:0] o_sample_filter,
	output logic o_adapt_locked,
	output logic o_adapt_step,
	// crc error flagging
	input wire logic [NUM_PORTS-1:0] i_crc_err,
	output logic [NUM_PORTS-1:0] o_crc_err_flag
);

	// ==========================================================================
	// declarations
	logic [7:0] ctl;
	logic [7:0] thold;
	logic [NUM_PORTS-1:0] crc_flag_en;
	logic [2:0] adapt_error_select;
	logic two_step_validate_enable;
	logic loop_order_select;
	logic sample_filter_adapt_enable;
	logic lock_meta_reg;
	logic lock_sync_reg;
	logic err_any;
	logic [7:0] err_count;
	logic accum_clear;
	aec_pkg::aec_state_t state_reg;
	aec_pkg::aec_state_t state_next;
	logic [RELOCK_W-1:0] cnt_reg;
	logic [RELOCK_W-1:0] cnt_next;
	logic [EQ_W-1:0] eq_reg;
	logic [EQ_W-1:0] eq_next;
	logic [3:0] sf_reg;
	logic [3:0] sf_next;
	logic locked_reg;
	logic locked_next;
	logic step_reg;
	logic step_next;
	logic [NUM_PORTS-1:0] crc_flag_reg;
	logic [NUM_PORTS-1:0] crc_flag_next;
	logic [RELOCK_W-1:0] full_limit;
	logic [RELOCK_W-1:0] half_limit;
	logic [RELOCK_W-1:0] settle_limit;
	logic settle_done;
	logic half_done;
	logic eq_at_max;
	logic sf_at_max;
	logic [EQ_W-1:0] eq_adv;
	logic [3:0] sf_adv;
	logic [EQ_W-1:0] eq_raise;

	// ==========================================================================
	// register file
	aec_regs #(
		.NUM_PORTS(NUM_PORTS),
		.PSEL_W(PSEL_W)
	) u_regs (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_reg_addr(i_reg_addr),
		.i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata),
		.i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata),
		.i_rd_port_sel(i_rd_port_sel),
		.i_wr_port_en(i_wr_port_en),
		.o_ctl(ctl),
		.o_thold(thold),
		.o_crc_flag_en(crc_flag_en)
	);

	// control fields
	assign adapt_error_select = ctl[`AEC_ERRSEL_MSB:`AEC_ERRSEL_LSB];
	assign two_step_validate_enable = ctl[`AEC_TWO_STEP_BIT];
	assign loop_order_select = ctl[`AEC_LOOP_ORDER_BIT];
	assign sample_filter_adapt_enable = ctl[`AEC_SF_EN_BIT];

	// ==========================================================================
	// error accumulator
	aec_err_accum #(
		.CNT_W(8)
	) u_accum (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_clear(accum_clear),
		.i_select(adapt_error_select),
		.i_link_err(i_link_err),
		.o_err_any(err_any),
		.o_err_count(err_count)
	);

	// ==========================================================================
	// lock level comes from the analog side: two flip-flop synchroniser
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			lock_meta_reg <= i_lock_async;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// ==========================================================================
	// timer limits, never below one cycle
	always_comb begin
		full_limit = (i_relock_period == '0) ? RELOCK_W'(1) : i_relock_period;
		half_limit = (i_relock_period[RELOCK_W-1:1] == '0) ? RELOCK_W'(1)
			: {1'b0, i_relock_period[RELOCK_W-1:1]};
		settle_limit = two_step_validate_enable ? half_limit : full_limit;
		settle_done = (cnt_reg >= (settle_limit - RELOCK_W'(1)));
		half_done = (cnt_reg >= (half_limit - RELOCK_W'(1)));
	end

	// ==========================================================================
	// next candidate setting for the nested sweep
	always_comb begin
		eq_at_max = (eq_reg >= EQ_W'(EQ_MAX));
		sf_at_max = (sf_reg >= i_sample_filter_upper_limit);
		eq_adv = eq_reg;
		sf_adv = sf_reg;
		if (!sample_filter_adapt_enable) begin
			// sample filter left out of the sweep, held at its centre
			eq_adv = eq_at_max ? EQ_W'(`AEC_EQ_START) : eq_reg + EQ_W'(1);
			sf_adv = `AEC_SF_CENTRE;
		end else if (!loop_order_select) begin
			// equalizer is the inner loop
			if (!eq_at_max) begin
				eq_adv = eq_reg + EQ_W'(1);
			end else begin
				eq_adv = EQ_W'(`AEC_EQ_START);
				sf_adv = sf_at_max ? i_sample_filter_lower_limit : sf_reg + 4'h1;
			end
		end else begin
			// sample filter is the inner loop
			if (!sf_at_max) begin
				sf_adv = sf_reg + 4'h1;
			end else begin
				sf_adv = i_sample_filter_lower_limit;
				eq_adv = eq_at_max ? EQ_W'(`AEC_EQ_START) : eq_reg + EQ_W'(1);
			end
		end
		// stronger equalizer, saturating at the top setting
		eq_raise = eq_at_max ? eq_reg : eq_reg + EQ_W'(1);
	end

	// ==========================================================================
	// adaption state machine: next values
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + RELOCK_W'(1);
		eq_next = eq_reg;
		sf_next = sf_reg;
		step_next = 1'b0;
		accum_clear = 1'b0;
		unique case (state_reg)
			aec_pkg::AEC_SETTLE: begin
				if (settle_done) begin
					cnt_next = '0;
					accum_clear = 1'b1;
					if (two_step_validate_enable) begin
						state_next = aec_pkg::AEC_VALIDATE;
					end else if (lock_sync_reg) begin
						state_next = aec_pkg::AEC_TRACK;
					end else begin
						eq_next = eq_adv;
						sf_next = sf_adv;
						step_next = 1'b1;
					end
				end
			end
			aec_pkg::AEC_VALIDATE: begin
				if (err_any) begin
					// candidate dropped at once
					state_next = aec_pkg::AEC_SETTLE;
					cnt_next = '0;
					eq_next = eq_adv;
					sf_next = sf_adv;
					step_next = 1'b1;
				end else if (half_done) begin
					cnt_next = '0;
					accum_clear = 1'b1;
					if (lock_sync_reg) begin
						state_next = aec_pkg::AEC_TRACK;
					end else begin
						state_next = aec_pkg::AEC_SETTLE;
						eq_next = eq_adv;
						sf_next = sf_adv;
						step_next = 1'b1;
					end
				end
			end
			aec_pkg::AEC_TRACK: begin
				if (!lock_sync_reg) begin
					// lost lock: resume the sweep
					state_next = aec_pkg::AEC_SETTLE;
					cnt_next = '0;
					eq_next = eq_adv;
					sf_next = sf_adv;
					step_next = 1'b1;
				end else if (half_done) begin
					// error window over half the relock period
					cnt_next = '0;
					accum_clear = 1'b1;
					if ((adapt_error_select != 3'h0) && (err_count > thold)) begin
						state_next = aec_pkg::AEC_SETTLE;
						eq_next = eq_raise;
						step_next = 1'b1;
					end
				end
			end
		endcase
		locked_next = (state_next == aec_pkg::AEC_TRACK);
	end

	// adaption state machine: registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_reg <= aec_pkg::AEC_SETTLE;
			cnt_reg <= '0;
			eq_reg <= EQ_W'(`AEC_EQ_START);
			sf_reg <= `AEC_SF_CENTRE;
			locked_reg <= 1'b0;
			step_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			eq_reg <= eq_next;
			sf_reg <= sf_next;
			locked_reg <= locked_next;
			step_reg <= step_next;
		end
	end

	assign o_eq_setting = eq_reg;
	assign o_sample_filter = sf_reg;
	assign o_adapt_locked = locked_reg;
	assign o_adapt_step = step_reg;

	// ==========================================================================
	// crc error flag gated per port by its capability bit
	always_comb begin
		crc_flag_next = i_crc_err & crc_flag_en;
	end

	// crc flag register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			crc_flag_reg <= '0;
		end else begin
			crc_flag_reg <= crc_flag_next;
		end
	end

	assign o_crc_err_flag = crc_flag_reg;

endmodule
`default_nettype wire

/* test/aec_ctrl_sva.sv */
// concurrent checks on the adaptive equalizer control ports
`timescale 1ns/1ns
`default_nettype none
module aec_ctrl_sva #(
	parameter int NUM_PORTS = 2,
	parameter int RELOCK_W = 16,
	parameter int EQ_W = 4
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	// adaption and crc
	input wire logic [RELOCK_W-1:0] i_relock_period,
	input wire logic i_lock_async,
	input wire logic [NUM_PORTS-1:0] i_crc_err,
	input wire logic [NUM_PORTS-1:0] o_crc_err_flag,
	input wire logic [EQ_W-1:0] o_eq_setting,
	input wire logic o_adapt_locked,
	input wire logic o_adapt_step
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic [15:0] gap_reg, gap_next;
	logic [3:0] lk_reg, lk_next;
	// cycles since the last step pulse and since lock went high
	always_comb begin
		gap_next = o_adapt_step ? 16'h0000 : gap_reg + 16'h0001;
		lk_next = !i_lock_async ? 4'h0 : ((lk_reg == 4'hf) ? lk_reg : lk_reg + 4'h1);
	end
	always_ff @(posedge i_core_clk) begin
		gap_reg <= i_rst ? 16'h0000 : gap_next;
		lk_reg <= i_rst ? 4'h0 : lk_next;
	end
	// ==========
	// properties
	sequence s_rd(a);
		i_reg_rd && i_reg_addr == a;
	endsequence
	sequence s_step_near;
		(o_adapt_step || $past(o_adapt_step)) or (##1 o_adapt_step);
	endsequence
	property p_ctl_top_bit;
		s_rd(8'h42) |=> !o_reg_rdata[7];
	endproperty
	a_ctl_top_bit: assert property (p_ctl_top_bit)
		else $error("control top bit read as one");
	property p_rdata_hold;
		!i_reg_rd |=> $stable(o_reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
	property p_crc_cause;
		|o_crc_err_flag |-> (o_crc_err_flag & ~$past(i_crc_err)) == '0;
	endproperty
	a_crc_cause: assert property (p_crc_cause)
		else $error("crc flag without crc error");
	property p_eq_order;
		$changed(o_eq_setting) |-> o_eq_setting == $past(o_eq_setting) + 1'b1;
	endproperty
	a_eq_order: assert property (p_eq_order)
		else $error("equalizer skipped a setting");
	property p_change_marked;
		$changed(o_eq_setting) |-> o_adapt_step;
	endproperty
	a_change_marked: assert property (p_change_marked)
		else $error("setting changed without step pulse");
	property p_lock_cause;
		$rose(o_adapt_locked) |-> lk_reg >= 4'h2;
	endproperty
	a_lock_cause: assert property (p_lock_cause)
		else $error("locked without lock indication");
	property p_unlock_steps;
		$fell(o_adapt_locked) |-> s_step_near;
	endproperty
	a_unlock_steps: assert property (p_unlock_steps)
		else $error("tracking left without a step");
	property p_settle_min;
		o_adapt_step |-> gap_reg + 16'h0002 >= 16'(i_relock_period >> 1);
	endproperty
	a_settle_min: assert property (p_settle_min)
		else $error("step sooner than half period");
endmodule
bind aec_ctrl aec_ctrl_sva #(.NUM_PORTS(NUM_PORTS), .RELOCK_W(RELOCK_W), .EQ_W(EQ_W)) aec_ctrl_sva_i (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_relock_period(i_relock_period), .i_lock_async(i_lock_async),
	.i_crc_err(i_crc_err), .o_crc_err_flag(o_crc_err_flag), .o_eq_setting(o_eq_setting),
	.o_adapt_locked(o_adapt_locked), .o_adapt_step(o_adapt_step));
`default_nettype wire

/* test/aec_serializer_model.sv */
// behavioural remote serializer: lock level and error pulses toward the port
`timescale 1ns/1ns
`default_nettype none
module aec_serializer_model (
	// clock
	input wire logic i_core_clk,
	// bench requests
	input wire logic i_link_up,
	input wire logic [2:0] i_err_kind,
	input wire logic [1:0] i_crc_kind,
	// toward the receiver
	output logic o_lock_async,
	output logic [2:0] o_link_err,
	output logic [1:0] o_crc_err
);
	// launched just after the edge so the receiver never samples a change;
	// one driver per output, the receiver sits in reset until the first launch
	always @(posedge i_core_clk) begin
		o_lock_async <= #2 i_link_up;
		o_link_err <= #2 i_err_kind;
		o_crc_err <= #2 i_crc_kind;
	end
endmodule
`default_nettype wire

/* test/adaptive_eq_control_test.sv */
// self-checking bench for the adaptive equalizer control
`timescale 1ns/1ns
`default_nettype none
module adaptive_eq_control_test;
	typedef struct {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
		logic [1:0] en;
		logic sel;
		logic [7:0] exp;
	} aec_row_t;
	logic clk, rst, reg_wr, reg_rd, rd_sel, lock_async, locked, step, link_up;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] wr_en, crc_err, crc_flag, crc_kind, seen;
	logic [2:0] link_err, err_kind, sel;
	logic [3:0] sf_lo, sf_hi, eq, sf, pre;
	logic [15:0] relock;
	int err_count, cmp_count, g, s;
	// register rows: write (optional), then read back
	aec_row_t rows [12] = '{
		'{8'h42, 1'b0, 8'h00, 2'h0, 1'b0, 8'h71},
		'{8'h43, 1'b0, 8'h00, 2'h0, 1'b0, 8'h01},
		'{8'h4a, 1'b0, 8'h00, 2'h0, 1'b0, 8'h00},
		'{8'h42, 1'b1, 8'hff, 2'h0, 1'b0, 8'h7f},
		'{8'h43, 1'b1, 8'h05, 2'h0, 1'b0, 8'h05},
		'{8'h44, 1'b1, 8'haa, 2'h0, 1'b0, 8'h00},
		'{8'h49, 1'b1, 8'h55, 2'h0, 1'b0, 8'h00},
		'{8'h4a, 1'b1, 8'h10, 2'h1, 1'b0, 8'h10},
		'{8'h4a, 1'b0, 8'h00, 2'h0, 1'b1, 8'h00},
		'{8'h4a, 1'b1, 8'hff, 2'h2, 1'b1, 8'hff},
		'{8'h4a, 1'b1, 8'h00, 2'h0, 1'b1, 8'hff},
		'{8'h60, 1'b1, 8'h12, 2'h0, 1'b0, 8'h00}};
	aec_ctrl aec_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(reg_addr),
		.i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
		.i_rd_port_sel(rd_sel), .i_wr_port_en(wr_en), .i_relock_period(relock),
		.i_lock_async(lock_async), .i_link_err(link_err), .i_sample_filter_lower_limit(sf_lo),
		.i_sample_filter_upper_limit(sf_hi), .o_eq_setting(eq), .o_sample_filter(sf),
		.o_adapt_locked(locked), .o_adapt_step(step), .i_crc_err(crc_err),
		.o_crc_err_flag(crc_flag));
	aec_serializer_model aec_serializer_model_i (.i_core_clk(clk), .i_link_up(link_up),
		.i_err_kind(err_kind), .i_crc_kind(crc_kind), .o_lock_async(lock_async),
		.o_link_err(link_err), .o_crc_err(crc_err));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic give_verdict();
		if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic reg_wr_op(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		wr_en = e;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic reg_rd_op(input logic [7:0] a, input logic p, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		rd_sel = p;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		check("read data", e, reg_rdata);
	endtask
	// wait for n steps; g ends as the gap before the last one
	task automatic steps(input int n);
		int k;
		k = 0;
		g = 0;
		for (int c = 0; c < 400 && k < n; c++) begin
			@(negedge clk);
			g++;
			if (step === 1'b1) begin
				k++;
				if (k < n) g = 0;
			end
		end
		if (k < n) begin
			err_count++;
			$display("Error step count expected %0d seen %0d", n, k);
			give_verdict();
		end
	endtask
	task automatic idle(input int n);
		s = 0;
		repeat (n) begin
			@(negedge clk);
			if (step !== 1'b0) s++;
		end
	endtask
	task automatic wait_lock();
		for (int c = 0; c < 80 && locked !== 1'b1; c++) @(negedge clk);
		if (locked !== 1'b1) begin
			err_count++;
			$display("Error lock expected 1 seen %b", locked);
			give_verdict();
		end
	endtask
	task automatic do_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rd_sel = 1'b0;
		wr_en = 2'h0;
		relock = 16'd8;
		sf_lo = 4'h5;
		sf_hi = 4'h9;
		link_up = 1'b0;
		err_kind = 3'h0;
		crc_kind = 2'h0;
		err_count = 0;
		cmp_count = 0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check("equalizer at reset", 8'h00, {4'h0, eq});
		check("filter at reset", 8'h07, {4'h0, sf});
		foreach (rows[i]) begin
			if (rows[i].wr === 1'b1) reg_wr_op(rows[i].addr, rows[i].wdata, rows[i].en);
			reg_rd_op(rows[i].addr, rows[i].sel, rows[i].exp);
		end
		// crc flag only for the port whose capability bit is set
		reg_wr_op(8'h4a, 8'h00, 2'h2);
		crc_kind = 2'h3; // encoder crc taken as enabled outside this port
		seen = 2'h0;
		@(negedge clk);
		crc_kind = 2'h0;
		repeat (4) @(negedge clk) seen = seen | crc_flag;
		check("crc flags", 8'h01, {6'h0, seen});
		// validation timing with the lock down
		err_kind = 3'h7;
		reg_wr_op(8'h42, 8'h70, 2'h0);
		steps(3);
		check("full wait gap", 8'h08, 8'(g));
		check("filter held", 8'h07, {4'h0, sf});
		reg_wr_op(8'h42, 8'h74, 2'h0);
		steps(3);
		check("abandon gap", 8'h05, 8'(g));
		err_kind = 3'h0;
		steps(3);
		check("two-step gap", 8'h08, 8'(g));
		// tracking: threshold and error selection
		do_reset();
		link_up = 1'b1;
		reg_wr_op(8'h43, 8'hff, 2'h0);
		reg_wr_op(8'h42, 8'h70, 2'h0);
		wait_lock();
		err_kind = 3'h7;
		idle(24);
		check("steps under high limit", 8'h00, 8'(s));
		err_kind = 3'h0;
		reg_wr_op(8'h43, 8'h01, 2'h0);
		for (int k = 0; k < 4; k++) begin
			sel = (k < 3) ? 3'(1 << k) : 3'h0;
			err_kind = 3'h0;
			reg_wr_op(8'h42, {1'b0, sel, 4'h0}, 2'h0);
			wait_lock();
			err_kind = ~sel;
			idle(24);
			check("steps from unselected errors", 8'h00, 8'(s));
			if (k < 3) begin
				pre = eq;
				err_kind = sel;
				steps(1);
				check("raised equalizer", {4'h0, pre + 4'h1}, {4'h0, eq});
			end
		end
		// loop nesting
		err_kind = 3'h0;
		link_up = 1'b0;
		do_reset();
		reg_wr_op(8'h42, 8'h01, 2'h0);
		steps(16);
		check("inner equalizer sweep", 8'h08, {eq, sf});
		do_reset();
		reg_wr_op(8'h42, 8'h03, 2'h0);
		steps(3);
		check("inner filter sweep", 8'h15, {eq, sf});
		give_verdict();
	end
endmodule
`default_nettype wire
